// ==== verilog/rssip_pkg.sv ====
// Purpose: constants and types of the codec symbol-input port
// Assumes: one rising-edge clock, reset low-active and asynchronous
// Notes:   symbol width is a build parameter, default below
//
// Operation
// - all state updates on rising clock edge
// - reset clears every state at once, asynchronously
// - device drives accept enable as read request
// - device captures data on edge after response
// - symbol, boundary, erasure ignored when valid low
// - new symbol needs valid and previous enable
// - one symbol per transfer, bus width symbol bits
// - erasure flag marks symbol when option built
// - symbol width parameter between 3 and 12
package rssip_pkg;

  // symbol width range and default
  localparam int SYM_W_MIN  = 3;
  localparam int SYM_W_MAX  = 12;
  localparam int SYM_W_DEF  = 8;

  // values after reset
  localparam logic RST_ENA   = 1'h0;
  localparam logic RST_FLAG  = 1'h0;

  // codeword framing states
  typedef enum logic {
    RSSIP_IDLE,
    RSSIP_WORD
  } rssip_state_t;

  // a transfer counts when valid meets the enable of the previous cycle
  function automatic logic rssip_take(input logic val, input logic enaPrev);
    return val & enaPrev;
  endfunction : rssip_take

endpackage : rssip_pkg

// ==== verilog/rssip_frame.sv ====
// Purpose: codeword framing tracker of the symbol-input port
// Assumes: take is the qualified transfer strobe of the top
// Notes:   reports a boundary mismatch as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module rssip_frame
  import rssip_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // qualified transfer
  input  wire logic take,
  input  wire logic first,
  input  wire logic last,
  // framing status
  output var  logic inWord,
  output var  logic frameErr
);

  rssip_state_t state;
  rssip_state_t next_state;
  logic         next_frameErr;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state    = state;
    next_frameErr = 1'h0;
    if (take) begin
      // first flag inside a codeword, or a symbol with no first flag outside one
      next_frameErr = (state == RSSIP_WORD) ? first : ~first;
      if (last) begin
        next_state = RSSIP_IDLE;
      end else begin
        next_state = RSSIP_WORD;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= RSSIP_IDLE;
      frameErr <= RST_FLAG;
    end else begin
      state    <= next_state;
      frameErr <= next_frameErr;
    end
  end

  assign inWord = (state == RSSIP_WORD);

endmodule : rssip_frame
`default_nettype wire

// ==== verilog/rssip_port.sv ====
// Purpose: streaming symbol-input port of the codec core
// Assumes: source is logic on ref_clk; reset released on a clock edge
// Notes:   erasure input only takes effect when ERASE_EN is set
`timescale 1ns/1ps
`default_nettype none
module rssip_port
  import rssip_pkg::*;
#(
  parameter int   SYM_W    = rssip_pkg::SYM_W_DEF,
  parameter logic ERASE_EN = 1'h0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // stream from the source
  input  wire logic             sinkVal,
  input  wire logic             sinkFirst,
  input  wire logic             sinkLast,
  input  wire logic [SYM_W-1:0] symIn,
  input  wire logic             erasIn,
  // flow control to the source
  output var  logic             sinkEna,
  // core side
  input  wire logic             coreReady,
  output var  logic             symStrobe,
  output var  logic [SYM_W-1:0] symData,
  output var  logic             symErase,
  output var  logic             symFirst,
  output var  logic             symLast,
  output var  logic             inWord,
  output var  logic             frameErr
);
  import rssip_pkg::*;

  logic             enaPrev;
  logic             take;
  logic             next_sinkEna;
  logic             next_enaPrev;
  logic             next_symStrobe;
  logic [SYM_W-1:0] next_symData;
  logic             next_symErase;
  logic             next_symFirst;
  logic             next_symLast;

  ////////////////////////////////////////////////////////////////////////
  // qualify with enable one cycle back
  assign take = rssip_take(sinkVal, enaPrev);

  always_comb begin
    next_sinkEna   = coreReady;
    next_enaPrev   = sinkEna;
    next_symStrobe = take;
    next_symData   = symData;
    next_symErase  = symErase;
    next_symFirst  = symFirst;
    next_symLast   = symLast;
    // inputs disregarded without a qualified valid
    if (take) begin
      next_symData  = symIn;
      // erasure only with the option built
      next_symErase = ERASE_EN & erasIn;
      next_symFirst = sinkFirst;
      next_symLast  = sinkLast;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sinkEna   <= RST_ENA;
      enaPrev   <= RST_ENA;
      symStrobe <= RST_FLAG;
      symData   <= '0;
      symErase  <= RST_FLAG;
      symFirst  <= RST_FLAG;
      symLast   <= RST_FLAG;
    end else begin
      sinkEna   <= next_sinkEna;
      enaPrev   <= next_enaPrev;
      symStrobe <= next_symStrobe;
      symData   <= next_symData;
      symErase  <= next_symErase;
      symFirst  <= next_symFirst;
      symLast   <= next_symLast;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // framing tracker on the same qualified strobe
  rssip_frame u_frame (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .take     (take),
    .first    (sinkFirst),
    .last     (sinkLast),
    .inWord   (inWord),
    .frameErr (frameErr)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  width_range_a: assert property (SYM_W >= SYM_W_MIN && SYM_W <= SYM_W_MAX)
    else $error("symbol width out of range");

  // enable is still in its reset value one edge after release
  ena_follows_a: assert property ($past(rst_n) |-> sinkEna == $past(coreReady))
    else $error("accept enable not following core readiness");

  capture_edge_a: assert property (
    sinkVal && enaPrev |=> symStrobe && symData == $past(symIn))
    else $error("symbol not captured on the next edge");

  no_take_a: assert property (!sinkVal |=> !symStrobe)
    else $error("strobe without valid");

  stale_ena_a: assert property (
    !sinkEna ##1 !sinkEna |=> !symStrobe)
    else $error("strobe without prior enable");

  data_hold_a: assert property (
    !symStrobe |-> $stable(symData) && $stable(symFirst) && $stable(symLast))
    else $error("captured symbol changed without transfer");

  erase_gate_a: assert property (
    symStrobe |-> symErase == (ERASE_EN & $past(erasIn)))
    else $error("erasure mark wrong");

  last_close_a: assert property (
    symStrobe && symLast && !(sinkVal && enaPrev) |-> !inWord)
    else $error("codeword not closed by last flag");

  first_err_a: assert property (
    take && inWord && sinkFirst |=> frameErr)
    else $error("misplaced first flag not reported");

  // must stay live while reset is low, so the default disable is overridden
  reset_ena_a: assert property (
    @(posedge ref_clk) disable iff (1'b0) !rst_n ##1 !rst_n |-> !sinkEna)
    else $error("enable high during reset");

  word_cv: cover property (
    symStrobe && symFirst ##[1:20] symStrobe && symLast);
  stall_cv: cover property (sinkEna ##1 !sinkEna ##1 sinkVal);
  erase_cv: cover property (symStrobe && symErase);
  err_cv: cover property (frameErr);

endmodule : rssip_port
`default_nettype wire

// ==== dv/rssip_src_model.sv ====
// Purpose: upstream symbol source model
// Assumes: answers the read enable one edge later
// Notes:   idle data shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module rssip_src_model #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // flow control
  input  wire logic         sinkEna,
  input  wire logic         stall,
  // stream
  output var  logic         sinkVal,
  output var  logic         sinkFirst,
  output var  logic         sinkLast,
  output var  logic [W-1:0] symIn,
  output var  logic         erasIn
);
  logic [W+2:0] pend[$];
  task automatic push(input logic [W+2:0] s);
    pend.push_back(s);
  endtask : push
  initial begin
    {sinkVal, sinkFirst, sinkLast, erasIn} = 4'h0;
    symIn = '0;
  end
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sinkVal <= 1'h0;
    end else if (sinkEna) begin
      if (!stall && pend.size() > 0) begin
        {sinkFirst, sinkLast, erasIn, symIn} <= pend.pop_front();
        sinkVal <= 1'h1;
      end else begin
        sinkVal <= 1'h0;
        symIn <= ~symIn;
      end
    end
  end
endmodule : rssip_src_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: self-checking bench of the symbol-input port
// Assumes: source model answers the read enable
// Notes:   symbols are {first, last, erase, data}
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rssip_pkg::*;
  logic ref_clk = 0, rst_n = 0, coreReady = 0, stall = 0;
  logic sinkVal, sinkFirst, sinkLast, erasIn, sinkEna, symStrobe;
  logic symErase, symFirst, symLast, inWord, frameErr;
  logic [7:0] symIn, symData;
  logic [10:0] exp[$];
  int num_errors = 0, n_tests = 0, nFrm = 0;
  always #12.5 ref_clk = ~ref_clk;
  rssip_port #(.SYM_W(8), .ERASE_EN(1'h1)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .sinkVal(sinkVal), .sinkFirst(sinkFirst), .sinkLast(sinkLast), .symIn(symIn),
    .erasIn(erasIn), .sinkEna(sinkEna), .coreReady(coreReady), .symStrobe(symStrobe),
    .symData(symData), .symErase(symErase), .symFirst(symFirst), .symLast(symLast),
    .inWord(inWord), .frameErr(frameErr));
  rssip_src_model #(.W(8)) src_u (.ref_clk(ref_clk), .rst_n(rst_n), .sinkEna(sinkEna),
    .stall(stall), .sinkVal(sinkVal), .sinkFirst(sinkFirst), .sinkLast(sinkLast),
    .symIn(symIn), .erasIn(erasIn));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic send(input logic [10:0] s);
    src_u.push(s);
    exp.push_back(s);
  endtask : send
  task automatic drain();
    for (int i = 0; i < 300 && exp.size() > 0; i++) @(negedge ref_clk);
    chk(exp.size() == 0, "symbols not delivered");
    if (exp.size() != 0) tally_and_finish();
  endtask : drain
  // captured symbols against the expected order
  always @(posedge ref_clk) begin
    if (rst_n === 1'b1 && symStrobe === 1'b1) begin
      chk(exp.size() > 0 && {symFirst, symLast, symErase, symData} === exp.pop_front(),
        "captured symbol wrong");
    end
    if (rst_n === 1'b1 && frameErr === 1'b1) nFrm++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_word();
    nFrm = 0;
    send(11'h4A5);
    send(11'h15A);
    send(11'h0FF);
    send(11'h200);
    drain();
    chk(inWord === 1'b0 && nFrm == 0, "word framing");
  endtask : t_word
  task automatic t_backpressure();
    send(11'h401);
    for (int i = 2; i < 6; i++) send(11'(i));
    send(11'h306);
    for (int i = 0; i < 24; i++) begin
      @(negedge ref_clk);
      coreReady = i[1];
    end
    coreReady = 1'b1;
    drain();
  endtask : t_backpressure
  task automatic t_stall();
    stall = 1'b1;
    send(11'h433);
    send(11'h344);
    repeat (6) @(negedge ref_clk);
    chk(exp.size() == 2, "symbol taken while not valid");
    stall = 1'b0;
    drain();
  endtask : t_stall
  task automatic t_frame();
    nFrm = 0;
    send(11'h255);
    send(11'h4AA);
    send(11'h4BB);
    send(11'h2CC);
    drain();
    repeat (2) @(negedge ref_clk);
    chk(nFrm == 2 && inWord === 1'b0, "missing frame error");
  endtask : t_frame
  task automatic t_async();
    send(11'h466);
    drain();
    chk(inWord === 1'b1, "word not open");
    #5 rst_n = 1'b0;
    #1 chk(sinkEna === 1'b0 && inWord === 1'b0, "reset not immediate");
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : t_async
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (9) @(negedge ref_clk);
    coreReady = 1'b1;
    @(negedge ref_clk);
    chk(sinkEna === 1'b0 && symStrobe === 1'b0, "outputs active in reset");
    @(posedge ref_clk) rst_n <= 1'b1;
    @(negedge ref_clk);
    t_word();
    t_backpressure();
    t_stall();
    t_frame();
    t_async();
    repeat (2) @(negedge ref_clk);
    t_word();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
